// file: include/seq_cfg_map.vh
// register map, field layout and status/mask positions of the sequencer sample configuration block
`ifndef SEQ_CFG_MAP_VH
`define SEQ_CFG_MAP_VH
// register byte offsets
`define OFF_SEQ1_INPUT_SELECT   12'h060
`define OFF_SEQ1_SAMPLE_CONTROL 12'h064
`define OFF_SEQ2_INPUT_SELECT   12'h080
`define OFF_SEQ2_SAMPLE_CONTROL 12'h084
`define OFF_SEQ_START           12'h0c0
`define OFF_IRQ_STATUS          12'h0c4
`define OFF_IRQ_MASK            12'h0c8
`define OFF_SEQ_STATE           12'h0cc
// writable bit masks, everything else reads zero
`define INPUT_SELECT_MASK       32'h0000_3333
`define INPUT_SELECT_MASK16     16'h3333
`define SAMPLE_CONTROL_MASK     32'h0000_ffff
`define RESET_VALUE             32'h0000_0000
// field positions inside one 4-bit sample slot of the control register
`define CTL_DIFF_BIT            0
`define CTL_LAST_BIT            1
`define CTL_IRQEN_BIT           2
`define CTL_TEMP_BIT            3
// width of one sample slot
`define SLOT_W                  4
// start register bits and status bits
`define START_SEQ1_BIT          0
`define START_SEQ2_BIT          1
`define STAT_SEQ1_BIT           0
`define STAT_SEQ2_BIT           1
`define STAT_W                  2
`endif

// file: rtl/seq_sample_config.v
// sample configuration registers and stepping logic for sequencers 1 and 2, with apb slave and interrupt
`timescale 1ns/1ps
`include "seq_cfg_map.vh"

module seq_sample_config
#(
  parameter NSAMP = 4                     // sample slots per sequencer
)
(
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // converter side, one sample at a time
  output reg         conv_req,
  output reg         conv_seq,
  output reg  [1:0]  conv_input_sel,
  output reg         conv_temp_sel,
  output reg         conv_diff_sel,
  input  wire        conv_done,
  // raw sample interrupt pulses and combined interrupt
  output reg  [1:0]  seq_raw_irq,
  output wire        irq
);

  // ***************************************************
  // state and storage
  // ***************************************************
  localparam ST_IDLE = 1'b0;              // no sequence running
  localparam ST_CONV = 1'b1;              // waiting for current sample done

  reg [15:0] in_sel_r   [0:1];           // input select register per sequencer
  reg [15:0] ctl_r      [0:1];           // sample control register per sequencer
  reg        state_r;                     // stepping state
  reg        seq_r;                       // sequencer being stepped
  reg [1:0]  samp_r;                      // current sample index
  reg [1:0]  pend_r;                      // start requests not yet served
  reg [`STAT_W-1:0] stat_r;               // sticky interrupt status
  reg [`STAT_W-1:0] mask_r;               // interrupt mask

  wire       wr_en  = psel & penable & pwrite;   // write takes effect in access phase
  wire       rd_ph  = psel & ~penable;           // read data captured after setup
  // pick the 4-bit slot of one sample out of a 16-bit configuration word
  function [3:0] slot_of;
    input [15:0] word;
    input [1:0]  idx;
    begin
      slot_of = word[idx * `SLOT_W +: `SLOT_W];
    end
  endfunction

  wire [1:0] samp_inc = samp_r + 2'h1;                                 // index of the following sample
  wire [3:0] slot     = slot_of(ctl_r[seq_r], samp_r);                // flags of the running sample
  wire [3:0] nslot    = slot_of(ctl_r[seq_r], samp_inc);              // flags of the following sample
  wire [3:0] nsel     = slot_of(in_sel_r[seq_r], samp_inc);           // input select of the following sample
  wire       last   = slot[`CTL_LAST_BIT] || (samp_r == NSAMP - 1);
  wire       done_ev = (state_r == ST_CONV) && conv_done;
  reg  [`STAT_W-1:0] set_ev;             // events setting status this cycle
  reg  [31:0] rd_nxt;                     // next read data
  reg         hit;                        // address decodes to a register

  // zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign irq     = |(stat_r & mask_r);

  // ***************************************************
  // read decode
  // ***************************************************
  // read data is registered during setup so it stands at the access edge
  always @*
  begin
    hit    = 1'b1;
    rd_nxt = `RESET_VALUE;
    case (paddr)
      `OFF_SEQ1_INPUT_SELECT:   rd_nxt = {16'h0000, in_sel_r[0]} & `INPUT_SELECT_MASK;
      `OFF_SEQ2_INPUT_SELECT:   rd_nxt = {16'h0000, in_sel_r[1]} & `INPUT_SELECT_MASK;
      `OFF_SEQ1_SAMPLE_CONTROL: rd_nxt = {16'h0000, ctl_r[0]};
      `OFF_SEQ2_SAMPLE_CONTROL: rd_nxt = {16'h0000, ctl_r[1]};
      `OFF_SEQ_START:           rd_nxt = {30'h0000_0000, pend_r};
      `OFF_IRQ_STATUS:          rd_nxt = {30'h0000_0000, stat_r};
      `OFF_IRQ_MASK:            rd_nxt = {30'h0000_0000, mask_r};
      `OFF_SEQ_STATE:           rd_nxt = {28'h000_0000, samp_r, seq_r, state_r};
      default:                  hit = 1'b0;
    endcase
  end

  // events from completed interrupt-enabled samples
  always @*
  begin
    set_ev = {`STAT_W{1'b0}};
    if (done_ev && slot[`CTL_IRQEN_BIT])
      set_ev[seq_r] = 1'b1;
  end

  // ***************************************************
  // registers and apb writes
  // ***************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_sel_r[0] <= 16'h0000;
      in_sel_r[1] <= 16'h0000;
      ctl_r[0]    <= 16'h0000;
      ctl_r[1]    <= 16'h0000;
      stat_r      <= {`STAT_W{1'b0}};
      mask_r      <= {`STAT_W{1'b0}};
      prdata      <= 32'h0000_0000;
    end
    else
    begin
      if (rd_ph)
        prdata <= rd_nxt;
      // sticky status: set wins over a write-one clear in the same cycle
      stat_r <= (stat_r & ~((wr_en && paddr == `OFF_IRQ_STATUS) ? pwdata[`STAT_W-1:0] : {`STAT_W{1'b0}}))
                | set_ev;
      if (wr_en)
      begin
        case (paddr)
          // only the four 2-bit select fields are stored
          `OFF_SEQ1_INPUT_SELECT:   in_sel_r[0] <= pwdata[15:0] & `INPUT_SELECT_MASK16;
          `OFF_SEQ2_INPUT_SELECT:   in_sel_r[1] <= pwdata[15:0] & `INPUT_SELECT_MASK16;
          // all low 16 bits are flags: diff, last, irq enable, temp per slot
          `OFF_SEQ1_SAMPLE_CONTROL: ctl_r[0]    <= pwdata[15:0];
          `OFF_SEQ2_SAMPLE_CONTROL: ctl_r[1]    <= pwdata[15:0];
          `OFF_IRQ_MASK:            mask_r      <= pwdata[`STAT_W-1:0];
          default:                  ;
        endcase
      end
    end
  end

  // ***************************************************
  // sample stepping
  // ***************************************************
  // sequencer 1 has priority when both are pending; a start while a
  // sequence runs is held pending, never dropped
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r        <= ST_IDLE;
      seq_r          <= 1'b0;
      samp_r         <= 2'h0;
      pend_r         <= 2'h0;
      conv_req       <= 1'b0;
      conv_seq       <= 1'b0;
      conv_input_sel <= 2'h0;
      conv_temp_sel  <= 1'b0;
      conv_diff_sel  <= 1'b0;
      seq_raw_irq    <= 2'h0;
    end
    else
    begin
      seq_raw_irq <= set_ev;
      conv_req    <= 1'b0;
      if (wr_en && paddr == `OFF_SEQ_START)
        pend_r <= pend_r | pwdata[1:0];
      case (state_r)
        ST_IDLE:
        begin
          if (pend_r != 2'h0)
          begin
            seq_r   <= ~pend_r[`START_SEQ1_BIT];
            samp_r  <= 2'h0;
            pend_r  <= pend_r & ~(pend_r[`START_SEQ1_BIT] ? 2'h1 : 2'h2)
                       | ((wr_en && paddr == `OFF_SEQ_START) ? pwdata[1:0] : 2'h0);
            state_r <= ST_CONV;
            conv_req <= 1'b1;
            conv_seq <= ~pend_r[`START_SEQ1_BIT];
            conv_input_sel <= in_sel_r[~pend_r[`START_SEQ1_BIT]][1:0];
            conv_temp_sel  <= ctl_r[~pend_r[`START_SEQ1_BIT]][`CTL_TEMP_BIT];
            conv_diff_sel  <= ctl_r[~pend_r[`START_SEQ1_BIT]][`CTL_DIFF_BIT];
          end
        end
        ST_CONV:
        begin
          if (conv_done)
          begin
            // stop after the flagged sample, or after the fourth as a safety net
            if (last)
              state_r <= ST_IDLE;
            else
            begin
              samp_r   <= samp_inc;
              conv_req <= 1'b1;
              conv_input_sel <= nsel[1:0];
              conv_temp_sel  <= nslot[`CTL_TEMP_BIT];
              conv_diff_sel  <= nslot[`CTL_DIFF_BIT];
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule

// file: sim/seq_cfg_properties.sv
// port checker for the sequencer sample configuration block
`timescale 1ns/1ps
`include "seq_cfg_map.vh"
module seq_cfg_props
#(
  parameter NSAMP = 4                  // sample slots per sequencer
)
(
  // clock, reset and apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pslverr,
  // converter side
  input wire        conv_req,
  input wire [1:0]  conv_input_sel,
  input wire        conv_temp_sel,
  input wire        conv_diff_sel,
  input wire        conv_done,
  input wire [1:0]  seq_raw_irq
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read access phase at one address
  sequence s_rd(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  property p_gap1; s_rd(`OFF_SEQ1_INPUT_SELECT) |-> (prdata & 32'hffff_cccc) == 0; endproperty
  property p_gap2; s_rd(`OFF_SEQ2_INPUT_SELECT) |-> (prdata & 32'hffff_cccc) == 0; endproperty
  property p_ctl;
    s_rd(`OFF_SEQ1_SAMPLE_CONTROL) or s_rd(`OFF_SEQ2_SAMPLE_CONTROL) |-> prdata[31:16] == 16'h0000;
  endproperty
  property p_err;
    pslverr |-> psel && penable && !(paddr inside {`OFF_SEQ1_INPUT_SELECT, `OFF_SEQ1_SAMPLE_CONTROL,
      `OFF_SEQ2_INPUT_SELECT, `OFF_SEQ2_SAMPLE_CONTROL, `OFF_SEQ_START, `OFF_IRQ_STATUS, `OFF_IRQ_MASK,
      `OFF_SEQ_STATE});
  endproperty
  property p_req; conv_req |=> !conv_req; endproperty
  // sample fields may only move together with a new request
  property p_fld; !conv_req |-> $stable({conv_input_sel, conv_temp_sel, conv_diff_sel}); endproperty
  property p_irq; seq_raw_irq != 2'b00 |-> $past(conv_done); endproperty
  property p_irq1; seq_raw_irq != 2'b00 |=> seq_raw_irq == 2'b00; endproperty
  a_gap1: assert property (p_gap1) else $error("input select gap bits set");
  a_gap2: assert property (p_gap2) else $error("input select gap bits set");
  a_ctl: assert property (p_ctl) else $error("control upper half set");
  a_err: assert property (p_err) else $error("error on mapped access");
  a_req: assert property (p_req) else $error("request longer than a cycle");
  a_fld: assert property (p_fld) else $error("sample fields moved");
  a_irq: assert property (p_irq) else $error("raw interrupt without completion");
  a_irq1: assert property (p_irq1) else $error("raw interrupt too long");
endmodule
bind seq_sample_config seq_cfg_props #(.NSAMP(NSAMP)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .conv_req(conv_req),
  .conv_input_sel(conv_input_sel), .conv_temp_sel(conv_temp_sel), .conv_diff_sel(conv_diff_sel),
  .conv_done(conv_done), .seq_raw_irq(seq_raw_irq));

// file: sim/seq_sample_config_tb_top.sv
// self-checking bench of the sequencer sample configuration block
`timescale 1ns/1ps
module seq_sample_config_tb_top;
  // ****************
  // stimulus and counters
  // ****************
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_done = 0, err;
  reg  [11:0] paddr = 0, a;
  reg  [31:0] pwdata = 0, rd;
  wire [31:0] prdata;
  wire [1:0]  seq_raw_irq, conv_input_sel;
  wire        pready, pslverr, conv_req, conv_seq, conv_temp_sel, conv_diff_sel, irq;
  integer     n_errors = 0, compares = 0, k;
  seq_sample_config u_seq_sample_config (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .conv_req(conv_req), .conv_seq(conv_seq), .conv_input_sel(conv_input_sel), .conv_temp_sel(conv_temp_sel),
    .conv_diff_sel(conv_diff_sel), .conv_done(conv_done), .seq_raw_irq(seq_raw_irq), .irq(irq));
  initial forever #20 pclk = ~pclk;
  // count and report one comparison
  task check(input string what, input [31:0] seen, exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // counts, verdict and end of run
  task conclude(input integer bad);
    n_errors = n_errors + bad;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task apb(input w, input [11:0] ad, input [31:0] d);
    integer i;
    @(posedge pclk) psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    for (i = 0; pready !== 1'b1 && i < 50; i++)
      @(posedge pclk);
    if (i == 50)
      conclude(1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // start a sequencer and play the converter, expecting fields from the programmed words
  task run(input s, input [31:0] mux, ctl);
    integer n, i;
    apb(1, 12'h0c0, 32'h1 << s);
    for (n = 0; n < 4; n++)
    begin
      for (i = 0; conv_req !== 1'b1 && i < 50; i++)
        @(negedge pclk);
      if (i == 50)
        conclude(1);
      check("fields", {conv_seq, conv_input_sel, conv_temp_sel, conv_diff_sel},
        {s, mux[4*n+:2], ctl[4*n+3], ctl[4*n]});
      @(posedge pclk) conv_done <= 1;
      @(posedge pclk) conv_done <= 0;
      @(negedge pclk);
      check("raw irq", seq_raw_irq[s], ctl[4*n+2]);
      if (ctl[4*n+1])
        n = 4;
    end
    // the end flag must stop the stepping
    repeat (8) @(negedge pclk) check("stop", conv_req, 0);
    $display("sequence %0d done", s);
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    for (k = 0; k < 4; k++)
    begin
      a = 12'h060 + k[1] * 12'h020 + k[0] * 4;
      apb(0, a, 0);
      check("reset", rd, 0);
      apb(1, a, 32'hffff_ffff);
      apb(0, a, 0);
      check("mask", rd, k[0] ? 32'h0000_ffff : 32'h0000_3333);
    end
    apb(1, 12'h070, 32'hffff_ffff);
    check("unmapped", err, 1);
    $display("register test done");
    apb(1, 12'h060, 32'h0000_0321);
    apb(1, 12'h064, 32'h0000_02c1);
    apb(1, 12'h0c8, 32'h1);
    run(0, 32'h0321, 32'h02c1);
    check("irq set", irq, 1);
    apb(1, 12'h0c4, 32'h1);
    @(negedge pclk) check("irq clear", irq, 0);
    apb(1, 12'h080, 32'h0000_3000);
    apb(1, 12'h084, 32'h0000_f000);
    run(1, 32'h3000, 32'hf000);
    check("irq masked", irq, 0);
    apb(0, 12'h0c4, 0);
    check("status", rd, 2);
    conclude(0);
  end
endmodule
